/* include/irq_unit_pkg.sv */
// constants, offsets and helpers of the vectored interrupt unit
// assumes one 10 MHz clock domain and a 32-bit AHB-Lite register port
package irq_unit_pkg;

   // ***************
   // sources
   // ***************
   localparam int NSRC = 19;
   localparam logic [18:0] SRC_IMPL = 19'h5ffff;
   // external inputs and the two first timers lose their flag on entry
   localparam logic [18:0] HWCLR_MASK = 19'h0000f;

   // ***************
   // vectors and timing
   // ***************
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] VEC_STEP = 16'h0008;
   localparam int DETECT_CYC = 1;
   localparam int CALL_CYC = 5;
   localparam logic [2:0] CALL_LAST = 3'(CALL_CYC - 1);

   // ***************
   // register map
   // ***************
   localparam logic [7:0] OFS_PEND = 8'h00;
   localparam logic [7:0] OFS_ENABLE = 8'h04;
   localparam logic [7:0] OFS_PRIO_A = 8'h08;
   localparam logic [7:0] OFS_PRIO_B = 8'h0c;
   localparam logic [7:0] OFS_PRIO_C = 8'h10;
   localparam logic [7:0] OFS_STATE = 8'h14;
   localparam logic [7:0] OFS_EVT = 8'h18;
   localparam logic [7:0] OFS_EMASK = 8'h1c;
   localparam int GLB_BIT = 31;
   localparam int PA_W = 7;
   localparam int PA_RSV_BIT = 7;
   localparam int PB_LSB = 7;
   localparam int PB_W = 8;
   localparam int PC_LSB = 15;
   localparam int PC_W = 4;
   localparam int ST_VEC_LSB = 16;
   localparam int ST_IDX_LSB = 4;
   localparam int EV_CALL = 0;
   localparam int EV_PREEMPT = 1;
   localparam int EV_RETURN_FROM_IRQ_OP = 2;
   localparam logic [2:0] SIZE_WORD = 3'h2;

   typedef enum logic [0:0] {SEQ_IDLE = 1'b0, SEQ_CALL = 1'b1} seq_t;

   function automatic logic [15:0] vec_of(input logic [4:0] idx);
      return VEC_BASE + 16'(idx) * VEC_STEP;
   endfunction : vec_of

endpackage : irq_unit_pkg

/* include/arb_if.sv */
// request bundle between the unit and its priority arbiter
// assumes both ends share one clock; the bundle itself is combinational
`timescale 1ns/1ps
`default_nettype none
interface arb_if;
   logic [18:0] req;
   logic [18:0] prio;
   logic hit;
   logic high;
   logic [4:0] idx;
   modport arb (input req, input prio, output hit, output high, output idx);
   modport user (output req, output prio, input hit, input high, input idx);
endinterface : arb_if
`default_nettype wire

/* hdl/irq_arbiter.sv */
// two-level fixed-order arbiter of the interrupt unit
// assumes requests already gated by enables; purely combinational
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter (
   // request bundle
   arb_if.arb a
);
   import irq_unit_pkg::*;

   // downward scan so the lowest index is the last to win
   always_comb begin
      a.hit = 1'b0;
      a.high = 1'b0;
      a.idx = 5'h00;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (a.req[i] && !a.prio[i]) begin
            a.hit = 1'b1;
            a.idx = 5'(i);
         end
      end
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (a.req[i] && a.prio[i]) begin
            a.hit = 1'b1;
            a.high = 1'b1;
            a.idx = 5'(i);
         end
      end
   end

endmodule : irq_arbiter
`default_nettype wire

/* hdl/irq_vector_unit.sv */
// vectored interrupt unit: flags, enables, two levels, call sequencing
// assumes cpu_* strobes from the instruction sequencer, AHB-Lite master
// Contract
// - eighteen sources plus reset, each with own vector and fixed slot
// - software writing a flag to one requests exactly like hardware
// - high preempts a running low handler; a high handler is never preempted
// - every priority bit reads low level after reset
// - high level first, then lowest fixed index wins
// - decode every cycle; best response one detect plus five call cycles
// - after a return one more instruction completes before the next call
// - worst response twenty cycles: detect, return, divide, call
// - equal or lower request waits for return plus one instruction
// - cpu stall defers dispatch by the stall length
// - vectors from 0x0003 stepping eight to 0x0093; reset 0x0000 outranks all
// - external and timer-overflow flags cleared on entry, others by software
// - one priority bit per source spread over three registers
// - global enable off masks every source
// - flags set regardless of enable; disabled flags ignored
// - flag still set after return re-requests after next instruction
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module irq_vector_unit (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // peripheral sources
   input wire logic [irq_unit_pkg::NSRC-1:0] src_event,
   input wire logic [irq_unit_pkg::NSRC-1:0] src_flag,
   // cpu sequencer
   input wire logic cpu_instr_end,
   input wire logic cpu_return_from_irq_op_done,
   input wire logic cpu_stall,
   output logic call_active,
   output logic [15:0] call_vector,
   output logic handler_entry,
   output logic irq
);
   import irq_unit_pkg::*;

   typedef struct packed {
      seq_t seq;
      logic [2:0] cnt;
      logic [18:0] pend;
      logic [18:0] en;
      logic [18:0] prio;
      logic glb;
      logic ins_lo;
      logic ins_hi;
      logic cur_hi;
      logic [4:0] cur_idx;
      logic [15:0] vec;
      logic entry;
      logic [2:0] evt;
      logic [2:0] emask;
      logic irq;
      logic a_wr;
      logic [7:0] a_addr;
      logic [31:0] rdata;
      logic rdy;
      logic err;
   } unit_t;

   localparam unit_t UNIT_RST = '{seq: SEQ_IDLE, vec: RESET_VECTOR, rdy: 1'b1, default: '0};

   unit_t st_q;
   unit_t st_d;
   logic [18:0] req;
   logic elig;
   logic go;
   logic hi_any;

   arb_if arb_bus ();

   irq_arbiter i_irq_arbiter (
      .a(arb_bus.arb)
   );

   // ****************************
   // request gating and eligibility
   // ****************************
   assign req = (st_q.pend | src_flag) & st_q.en & SRC_IMPL & {NSRC{st_q.glb}};
   assign arb_bus.req = req;
   assign arb_bus.prio = st_q.prio;
   assign hi_any = |(req & st_q.prio);
   // a high handler blocks all, a low one blocks only low requests
   assign elig = arb_bus.hit && (arb_bus.high ? !st_q.ins_hi : !(st_q.ins_hi || st_q.ins_lo));
   // the return's own boundary is refused, so one more instruction must end
   assign go = elig && cpu_instr_end && !cpu_stall && !cpu_return_from_irq_op_done;

   // ****************************
   // next state
   // ****************************
   always_comb begin
      logic [2:0] ev;
      ev = 3'h0;
      st_d = st_q;
      st_d.entry = 1'b0;
      st_d.rdy = 1'b1;
      st_d.err = 1'b0;
      if (st_q.a_wr) begin
         case (st_q.a_addr)
            OFS_PEND: st_d.pend = hwdata[NSRC-1:0];
            OFS_ENABLE: begin
               st_d.en = hwdata[NSRC-1:0];
               st_d.glb = hwdata[GLB_BIT];
            end
            OFS_PRIO_A: st_d.prio[PA_W-1:0] = hwdata[PA_W-1:0];
            OFS_PRIO_B: st_d.prio[PB_LSB +: PB_W] = hwdata[PB_W-1:0];
            OFS_PRIO_C: st_d.prio[PC_LSB +: PC_W] = hwdata[PC_W-1:0];
            OFS_EVT: st_d.evt = st_q.evt & ~hwdata[2:0];
            OFS_EMASK: st_d.emask = hwdata[2:0];
            default: st_d.err = 1'b0;
         endcase
      end
      if (cpu_return_from_irq_op_done) begin
         ev[EV_RETURN_FROM_IRQ_OP] = 1'b1;
         if (st_q.ins_hi) begin
            st_d.ins_hi = 1'b0;
         end else begin
            st_d.ins_lo = 1'b0;
         end
      end
      case (st_q.seq)
         SEQ_IDLE: begin
            if (go) begin
               st_d.seq = SEQ_CALL;
               st_d.cnt = CALL_LAST;
               st_d.cur_idx = arb_bus.idx;
               st_d.cur_hi = arb_bus.high;
               st_d.vec = vec_of(arb_bus.idx);
               ev[EV_CALL] = 1'b1;
               ev[EV_PREEMPT] = st_q.ins_lo;
            end
         end
         SEQ_CALL: begin
            if (st_q.cnt == 3'h0) begin
               st_d.seq = SEQ_IDLE;
               st_d.entry = 1'b1;
               if (st_q.cur_hi) begin
                  st_d.ins_hi = 1'b1;
               end else begin
                  st_d.ins_lo = 1'b1;
               end
               if (HWCLR_MASK[st_q.cur_idx]) begin
                  st_d.pend[st_q.cur_idx] = 1'b0;
               end
            end else begin
               st_d.cnt = st_q.cnt - 3'h1;
            end
         end
         default: st_d.seq = SEQ_IDLE;
      endcase
      // set wins over any clear in the same cycle
      st_d.pend = (st_d.pend | src_event) & SRC_IMPL;
      st_d.evt = st_d.evt | ev;
      st_d.irq = |(st_d.evt & st_d.emask);
      // ****************************
      // bus address phase
      // ****************************
      st_d.a_wr = hsel && htrans[1] && hready && hwrite && (hsize == SIZE_WORD);
      st_d.a_addr = haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
         case (haddr[7:0])
            OFS_PEND: st_d.rdata = 32'(st_q.pend);
            OFS_ENABLE: st_d.rdata = 32'(st_q.en) | (32'(st_q.glb) << GLB_BIT);
            OFS_PRIO_A: st_d.rdata = 32'(st_q.prio[PA_W-1:0]) | (32'h1 << PA_RSV_BIT);
            OFS_PRIO_B: st_d.rdata = 32'(st_q.prio[PB_LSB +: PB_W]);
            OFS_PRIO_C: st_d.rdata = 32'(st_q.prio[PC_LSB +: PC_W]);
            OFS_STATE: begin
               st_d.rdata = (32'(st_q.vec) << ST_VEC_LSB) | (32'(st_q.cur_idx) << ST_IDX_LSB)
                  | 32'({st_q.cur_hi, st_q.seq == SEQ_CALL, st_q.ins_hi, st_q.ins_lo});
            end
            OFS_EVT: st_d.rdata = 32'(st_q.evt);
            OFS_EMASK: st_d.rdata = 32'(st_q.emask);
            default: st_d.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= UNIT_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************
   // outputs
   // ****************************
   assign hrdata = st_q.rdata;
   assign hreadyout = st_q.rdy;
   assign hresp = st_q.err;
   assign call_active = (st_q.seq == SEQ_CALL);
   assign call_vector = st_q.vec;
   assign handler_entry = st_q.entry;
   assign irq = st_q.irq;

   // ****************************
   // checks
   // ****************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_call_run;
      call_active [*5] ##1 (!call_active && handler_entry);
   endsequence

   property p_call_five;
      $rose(call_active) |-> s_call_run;
   endproperty
   a_call_five: assert property (p_call_five) else $error("call not five cycles");

   property p_stall_defers;
      cpu_stall && !call_active |=> !call_active;
   endproperty
   a_stall_defers: assert property (p_stall_defers) else $error("dispatch during stall");

   property p_return_from_irq_op_wait;
      cpu_return_from_irq_op_done && !call_active |=> !call_active;
   endproperty
   a_return_from_irq_op_wait: assert property (p_return_from_irq_op_wait) else $error("call right after return");

   property p_hi_not_preempted;
      st_q.ins_hi && !call_active |=> !call_active;
   endproperty
   a_hi_not_preempted: assert property (p_hi_not_preempted) else $error("high handler preempted");

   property p_global_off;
      !st_q.glb && !call_active |=> !call_active;
   endproperty
   a_global_off: assert property (p_global_off) else $error("call with global enable off");

   property p_vector_range;
      $rose(call_active) |-> call_vector == vec_of(st_q.cur_idx) && call_vector[2:0] == 3'h3
         && call_vector <= 16'h0093;
   endproperty
   a_vector_range: assert property (p_vector_range) else $error("bad vector");

   property p_level_first;
      $rose(call_active) |-> st_q.cur_hi == $past(hi_any);
   endproperty
   a_level_first: assert property (p_level_first) else $error("level order wrong");

   property p_entry_marks;
      handler_entry |-> (st_q.cur_hi ? st_q.ins_hi : st_q.ins_lo);
   endproperty
   a_entry_marks: assert property (p_entry_marks) else $error("level not in service");

   property p_irq_level;
      ##1 irq == $past(|(st_d.evt & st_d.emask));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq not following status");

   property p_flag_set;
      |src_event |=> (st_q.pend & $past(src_event & SRC_IMPL)) == $past(src_event & SRC_IMPL);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("event did not set its flag");

   // a fresh event at the entry edge is allowed to keep the flag up
   property p_hw_clear;
      handler_entry && HWCLR_MASK[st_q.cur_idx] && !$past(src_event[st_q.cur_idx])
         |-> !st_q.pend[st_q.cur_idx];
   endproperty
   a_hw_clear: assert property (p_hw_clear) else $error("flag not cleared on entry");

   property p_high_preempts;
      $rose(call_active) && st_q.ins_lo |-> st_q.cur_hi;
   endproperty
   a_high_preempts: assert property (p_high_preempts) else $error("low call over low handler");

   property p_low_waits;
      st_q.ins_lo && !hi_any && !call_active |=> !call_active;
   endproperty
   a_low_waits: assert property (p_low_waits) else $error("equal level not held off");

   property p_go_call;
      go && !call_active |=> call_active;
   endproperty
   a_go_call: assert property (p_go_call) else $error("decoded request not dispatched");

   property p_return_from_irq_op_high;
      cpu_return_from_irq_op_done && !call_active && st_q.ins_hi |=> !st_q.ins_hi;
   endproperty
   a_return_from_irq_op_high: assert property (p_return_from_irq_op_high) else $error("high level not released");

   property p_return_from_irq_op_low;
      cpu_return_from_irq_op_done && !call_active && !st_q.ins_hi |=> !st_q.ins_lo;
   endproperty
   a_return_from_irq_op_low: assert property (p_return_from_irq_op_low) else $error("low level not released");

endmodule : irq_vector_unit
`default_nettype wire

/* dv/cpu_seq_model.sv */
// cpu sequencer stand-in: instruction ends, returns and stalls
// assumes the bench commands returns, stalls and instruction length
`timescale 1ns/1ps
`default_nettype none
module cpu_seq_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // unit side
   input wire logic call_active,
   output logic cpu_instr_end,
   output logic cpu_return_from_irq_op_done,
   output logic cpu_stall,
   // bench commands
   input wire logic return_from_irq_op_go,
   input wire logic stall_go,
   input wire logic [3:0] instr_len
);
   logic [3:0] cnt_q;
   logic ret_q;
   assign cpu_stall = stall_go;
   // nothing completes while a call runs or the core is stalled
   assign cpu_instr_end = (cnt_q >= instr_len - 4'h1) && !call_active && !stall_go;
   // a return ends on an ordinary instruction boundary
   assign cpu_return_from_irq_op_done = ret_q && cpu_instr_end;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 4'h0;
         ret_q <= 1'b0;
      end else begin
         if (cpu_instr_end || call_active) cnt_q <= 4'h0;
         else if (!stall_go) cnt_q <= cnt_q + 4'h1;
         if (return_from_irq_op_go) ret_q <= 1'b1;
         else if (cpu_return_from_irq_op_done) ret_q <= 1'b0;
      end
   end
endmodule : cpu_seq_model
`default_nettype wire

/* dv/test_two_level_vectored_interrupt_unit.sv */
// self-checking bench of the vectored interrupt unit
// assumes irq_unit_pkg compiled first and the cpu model beside it
`timescale 1ns/1ps
`default_nettype none
module test_two_level_vectored_interrupt_unit;
   import irq_unit_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = SIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic [18:0] src_event = 19'h0;
   logic [18:0] src_flag = 19'h0;
   logic return_from_irq_op_go = 1'b0;
   logic stall_go = 1'b0;
   logic [3:0] instr_len = 4'h1;
   logic [31:0] hrdata, d;
   logic [15:0] call_vector;
   logic hreadyout, hresp, call_active, handler_entry, irq, cpu_instr_end, cpu_return_from_irq_op_done, cpu_stall;
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   always #50 hclk = ~hclk;
   irq_vector_unit i_irq_vector_unit (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_event, .src_flag, .cpu_instr_end, .cpu_return_from_irq_op_done,
      .cpu_stall, .call_active, .call_vector, .handler_entry, .irq);
   cpu_seq_model i_cpu_seq_model (.hclk, .hresetn, .call_active, .cpu_instr_end, .cpu_return_from_irq_op_done, .cpu_stall,
      .return_from_irq_op_go, .stall_go, .instr_len);
   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one single word transfer; read data lands in d
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask : xfer
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(d, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask : rc
   // n counts falling edges, one per cycle, up to the entry pulse
   task automatic went(input logic [31:0] vec);
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (handler_entry !== 1'b1 && n < 200);
      chk({31'h0, handler_entry}, 32'h1);
      chk({16'h0, call_vector}, vec);
   endtask : went
   task automatic ret;
      @(posedge hclk);
      return_from_irq_op_go <= 1'b1;
      @(posedge hclk);
      return_from_irq_op_go <= 1'b0;
      do @(negedge hclk); while (cpu_return_from_irq_op_done !== 1'b1);
   endtask : ret
   // one-cycle event pulse; returns at the edge that samples it
   task automatic pev(input int i);
      @(posedge hclk);
      src_event <= 19'h1 << i;
      @(posedge hclk);
      src_event <= 19'h0;
   endtask : pev
   function automatic logic [31:0] vx(input int i);
      return 32'(VEC_BASE) + 32'(i) * 32'(VEC_STEP);
   endfunction : vx
   // hang guard, far above the few hundred cycles needed
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude;
      end
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rc(OFS_PRIO_A, 32'h80);
      rc(OFS_PRIO_B, 32'h0);
      rc(OFS_PRIO_C, 32'h0);
      rc(8'h20, 32'h0);
      xfer(1'b1, OFS_PEND, 32'h20000);
      rc(OFS_PEND, 32'h0);
      for (int i = 0; i < NSRC; i++) begin
         if (i == 17) continue;
         xfer(1'b1, OFS_ENABLE, 32'h8000_0000 | (32'h1 << i));
         xfer(1'b1, OFS_PEND, 32'h1 << i);
         went(vx(i));
         rc(OFS_PEND, i < 4 ? 32'h0 : 32'h1 << i);
         xfer(1'b1, OFS_PEND, 32'h0);
         ret;
      end
      xfer(1'b1, OFS_ENABLE, 32'h8000_0013);
      pev(0);
      went(vx(0));
      chk(n, 1 + DETECT_CYC + CALL_CYC);
      ret;
      pev(1);
      stall_go <= 1'b1;
      fork
         went(vx(1));
         begin
            repeat (10) @(posedge hclk);
            stall_go <= 1'b0;
         end
      join
      chk(n, 1 + 10 + DETECT_CYC + CALL_CYC);
      ret;
      // low handler preempted by high, status and mask
      xfer(1'b1, OFS_PRIO_A, 32'h3);
      xfer(1'b1, OFS_EMASK, 32'h2);
      pev(4);
      went(vx(4));
      chk(irq, 1'b0);
      xfer(1'b1, OFS_PEND, 32'h0);
      xfer(1'b1, OFS_EVT, 32'h7);
      pev(0);
      went(vx(0));
      rc(OFS_EVT, 32'h3);
      chk(irq, 1'b1);
      xfer(1'b1, OFS_EVT, 32'h2);
      rc(OFS_EVT, 32'h1);
      chk(irq, 1'b0);
      pev(1);
      repeat (20) @(negedge hclk);
      chk(call_active, 1'b0);
      rc(OFS_STATE, {16'h0003, 7'h0, 5'h0, 4'hb});
      ret;
      went(vx(1));
      chk(n, 2 + CALL_CYC);
      ret;
      xfer(1'b0, OFS_STATE, 32'h0);
      chk(d & 32'h3, 32'h1);
      ret;
      // same-cycle requests, global enable off first
      xfer(1'b1, OFS_ENABLE, 32'h340);
      xfer(1'b1, OFS_PRIO_B, 32'h4);
      xfer(1'b1, OFS_PEND, 32'h340);
      repeat (10) @(negedge hclk);
      chk(call_active, 1'b0);
      rc(OFS_PEND, 32'h340);
      xfer(1'b1, OFS_ENABLE, 32'h8000_0340);
      went(vx(9));
      xfer(1'b1, OFS_PEND, 32'h140);
      ret;
      went(vx(6));
      xfer(1'b1, OFS_PEND, 32'h0);
      ret;
      // level flag survives the return, slow next instruction
      xfer(1'b1, OFS_ENABLE, 32'h8000_0020);
      @(posedge hclk);
      src_flag <= 19'h20;
      went(vx(5));
      @(posedge hclk);
      instr_len <= 4'h8;
      ret;
      went(vx(5));
      chk(n, 8 + CALL_CYC + 1);
      @(posedge hclk);
      src_flag <= 19'h0;
      instr_len <= 4'h1;
      ret;
      conclude;
   end
endmodule : test_two_level_vectored_interrupt_unit
`default_nettype wire
